/* verilog/rfs_pkg.sv */
// Package of constants and carrier types for the radio frame status bank
`default_nettype none
package rfs_pkg;
  // ----------------------------------------------------------------------
  // Register offsets on the serial port
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_CAL_STATE = 7'h32;
  localparam logic [6:0] ADDR_BUF_CHAN = 7'h33;
  localparam logic [6:0] ADDR_RX_THR = 7'h34;
  localparam logic [6:0] ADDR_OPTIONS = 7'h35;
  localparam logic [6:0] ADDR_CLEAR_CHANNEL_THRESHOLD = 7'h36;
  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [6:0] RX_THR_RST = 7'h40;
  localparam logic [1:0] OPTIONS_RST = 2'h1;
  localparam logic [7:0] CLEAR_CHANNEL_THRESHOLD_RST = 8'he0;
  localparam int OPT_GUARD_BIT = 0;
  localparam int OPT_SLOTTED_BIT = 1;
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [2:0] SPI_PINS_RST = 3'h5;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYMBOL_NS = 16000;
  localparam int TURN_SYMBOLS = 12;
  localparam int SYMBOL_CYCLES = SYMBOL_NS / CLK_PERIOD_NS;
  localparam int TURN_CYCLES = TURN_SYMBOLS * SYMBOL_CYCLES;
  // ----------------------------------------------------------------------
  // Clear-channel modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CCA_ALWAYS = 2'h0;
  localparam logic [1:0] CCA_BY_RSSI = 2'h1;
  localparam logic [1:0] CCA_NOT_RX = 2'h2;
  localparam logic [1:0] CCA_BOTH = 2'h3;
  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cal_done;
    logic synth_cal_in_progress;
    logic [5:0] state;
  } rfs_stat0_t;
  typedef struct packed {
    logic rx_data;
    logic thr_flag;
    logic sfd;
    logic cca;
    logic latched_cca;
    logic lock;
    logic tx_active;
    logic rx_active;
  } rfs_stat1_t;
  typedef struct packed {
    logic synth_cal_in_progress;
    logic cal_done;
    logic [5:0] state;
    logic lock;
    logic tx_active;
    logic rx_active;
    logic receiving;
    logic [7:0] rssi;
    logic [1:0] clear_channel_mode;
    logic [2:0] clear_channel_hysteresis;
  } rfs_radio_t;
  typedef struct packed {
    logic [7:0] byte_count;
    logic [7:0] filtered_count;
    logic frames_present;
    logic overflow;
    logic byte_read;
  } rfs_rxbuf_t;
  typedef struct packed {
    logic sfd_seen;
    logic frame_done;
    logic sample_strobe;
    logic tx_if_clear_strobe;
    logic ack_req_end;
    logic rx_end;
    logic backoff_boundary;
  } rfs_events_t;
endpackage : rfs_pkg
`default_nettype wire

/* verilog/rfs_status_bank.sv */
// Status and option register bank of the frame-control machine
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Calibration status bit 6 is high while synthesizer calibration runs.
// - Bit 7 pulses one cycle when calibration may be switched off.
// - Bits 5:0 show the frame machine state, read only.
// - Receive data bit high when buffer holds data, low during overflow.
// - Threshold flag sets when filtered bytes exceed the threshold.
// - Threshold flag also sets when a complete frame is buffered.
// - Flag clears when a read leaves fewer bytes than threshold, no frame.
// - Threshold flag held high during buffer overflow.
// - In transmit, start-of-frame bit high from delimiter sent to frame end.
// - In receive, start-of-frame bit high from delimiter received to frame end.
// - Bit 4 carries live clear-channel value, also driven to the pin.
// - Bit 3 latches clear-channel value on sample or transmit-if-clear strobe.
// - Bit 2 shows synthesizer lock.
// - Bit 1 shows transmit states, bit 0 receive states.
// - Seven-bit threshold field, reset 0x40, bit 7 reads zero.
// - With option bit 1 clear, acknowledge is sent twelve symbols after requesting frame.
// - Option bit 1 sends acknowledge at first backoff slot after twelve symbols.
// - Turnaround option applies a guard of twelve symbols less one cycle after reception ends.
// - Signed clear-channel threshold, reset 0xE0; clear when signal is below.
// - Mode selects always, strength with hysteresis, not receiving, or both.
module rfs_status_bank #(
  parameter int ACK_DELAY_CYCLES = rfs_pkg::TURN_CYCLES,
  parameter int GUARD_CYCLES = rfs_pkg::TURN_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  input wire rfs_pkg::rfs_radio_t i_radio,
  input wire rfs_pkg::rfs_rxbuf_t i_rxbuf,
  input wire rfs_pkg::rfs_events_t i_events,
  output logic o_spi_miso,
  output logic o_cca,
  output logic o_ack_start,
  output logic o_rx_guard
);
  import rfs_pkg::*;

  // ----------------------------------------------------------------------
  // Serial port: three-stage sync, accepted once stages two and three agree
  // ----------------------------------------------------------------------
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_reg;
  logic [2:0] pin_next;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_sh_reg;
  wire cs_n = pin_reg[2];
  wire sclk_rise = pin_next[1] & ~pin_reg[1];
  wire sclk_fall = ~pin_next[1] & pin_reg[1];
  wire mosi = pin_next[0];
  wire cmd_done = sclk_rise & ~cs_n & (bit_cnt_reg == 4'h7);
  wire data_done = sclk_rise & ~cs_n & (bit_cnt_reg == 4'hf);
  wire [7:0] rx_byte = {shift_reg, mosi};
  wire wr_en = data_done & cmd_reg[CMD_WRITE_BIT];

  // Bits change only where the last two stages agree, so a metastable first
  // stage never reaches the decoder
  wire [2:0] pin_agree = pin_s2_reg ~^ pin_s3_reg;
  assign pin_next = (pin_s3_reg & pin_agree) | (pin_reg & ~pin_agree);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_s1_reg <= SPI_PINS_RST;
      pin_s2_reg <= SPI_PINS_RST;
      pin_s3_reg <= SPI_PINS_RST;
      pin_reg <= SPI_PINS_RST;
    end else begin
      pin_s1_reg <= {i_spi_cs_n, i_spi_sclk, i_spi_mosi};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= pin_next;
    end
  end

  // Frame: command byte {write, offset[6:0]}, then one data byte, MSB first
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      cmd_reg <= 8'h00;
    end else if (cs_n) begin
      bit_cnt_reg <= 4'h0;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg <= rx_byte[6:0];
      if (cmd_done) begin
        cmd_reg <= rx_byte;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  logic [6:0] rx_thr_reg;
  logic [1:0] options_reg;
  logic [7:0] clear_channel_threshold_reg;

  // Reserved bits are dropped on write so they always read back zero
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_thr_reg <= RX_THR_RST;
      options_reg <= OPTIONS_RST;
      clear_channel_threshold_reg <= CLEAR_CHANNEL_THRESHOLD_RST;
    end else if (wr_en) begin
      if (cmd_reg[6:0] == ADDR_RX_THR) rx_thr_reg <= rx_byte[6:0];
      if (cmd_reg[6:0] == ADDR_OPTIONS) options_reg <= rx_byte[1:0];
      if (cmd_reg[6:0] == ADDR_CLEAR_CHANNEL_THRESHOLD) clear_channel_threshold_reg <= rx_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Clear-channel assessment
  // ----------------------------------------------------------------------
  logic rssi_clear_reg;
  logic cca_reg;
  logic latched_reg;
  wire signed [8:0] rssi_s = {i_radio.rssi[7], i_radio.rssi};
  wire signed [8:0] thr_s = {clear_channel_threshold_reg[7], clear_channel_threshold_reg};
  wire signed [8:0] low_s = thr_s - $signed({6'h00, i_radio.clear_channel_hysteresis});
  wire rssi_below = rssi_s < low_s;
  wire rssi_above = rssi_s >= thr_s;
  wire rssi_clear_next = rssi_below | (rssi_clear_reg & ~rssi_above);
  wire not_rx = ~i_radio.receiving;
  logic cca_next;

  // Mode decode; the signal-strength term keeps its hysteresis memory
  always_comb begin
    unique case (i_radio.clear_channel_mode)
      CCA_ALWAYS: cca_next = 1'b1;
      CCA_BY_RSSI: cca_next = rssi_clear_next;
      CCA_NOT_RX: cca_next = not_rx;
      CCA_BOTH: cca_next = rssi_clear_next & not_rx;
    endcase
  end

  wire strobe = i_events.sample_strobe | i_events.tx_if_clear_strobe;

  // Latched copy samples the live value visible at the strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rssi_clear_reg <= 1'b0;
      cca_reg <= 1'b0;
      latched_reg <= 1'b0;
    end else begin
      rssi_clear_reg <= rssi_clear_next;
      cca_reg <= cca_next;
      latched_reg <= strobe ? cca_reg : latched_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Receive buffer flags and start-of-frame bit
  // ----------------------------------------------------------------------
  logic thr_flag_reg;
  logic sfd_reg;
  wire thr_over = i_rxbuf.filtered_count > {1'b0, rx_thr_reg};
  wire thr_under = i_rxbuf.byte_count < {1'b0, rx_thr_reg};
  wire thr_clear = i_rxbuf.byte_read & thr_under & ~i_rxbuf.frames_present;
  // Any set term wins over a clear in the same cycle
  wire thr_set = thr_over | i_rxbuf.frames_present | i_rxbuf.overflow;
  wire thr_flag_next = thr_set | (thr_flag_reg & ~thr_clear);
  wire sfd_next = i_events.sfd_seen | (sfd_reg & ~i_events.frame_done);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      thr_flag_reg <= 1'b0;
      sfd_reg <= 1'b0;
    end else begin
      thr_flag_reg <= thr_flag_next;
      sfd_reg <= sfd_next;
    end
  end

  // ----------------------------------------------------------------------
  // Status words, one cycle behind the radio inputs
  // ----------------------------------------------------------------------
  rfs_stat0_t stat0_reg;
  rfs_stat1_t stat1;
  logic rx_data_reg;
  logic lock_reg;
  logic tx_act_reg;
  logic rx_act_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat0_reg <= '0;
      rx_data_reg <= 1'b0;
      lock_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      rx_act_reg <= 1'b0;
    end else begin
      stat0_reg <= {i_radio.cal_done, i_radio.synth_cal_in_progress, i_radio.state};
      rx_data_reg <= (i_rxbuf.byte_count != 8'h00) & ~i_rxbuf.overflow;
      lock_reg <= i_radio.lock;
      tx_act_reg <= i_radio.tx_active;
      rx_act_reg <= i_radio.rx_active;
    end
  end

  assign stat1 = {rx_data_reg, thr_flag_reg, sfd_reg, cca_reg, latched_reg,
                  lock_reg, tx_act_reg, rx_act_reg};

  // Read mux; unmapped offsets read zero
  wire [6:0] rd_addr = rx_byte[6:0];
  wire [7:0] rd_data = (rd_addr == ADDR_CAL_STATE) ? stat0_reg :
                       (rd_addr == ADDR_BUF_CHAN) ? stat1 :
                       (rd_addr == ADDR_RX_THR) ? {1'b0, rx_thr_reg} :
                       (rd_addr == ADDR_OPTIONS) ? {6'h00, options_reg} :
                       (rd_addr == ADDR_CLEAR_CHANNEL_THRESHOLD) ? clear_channel_threshold_reg : 8'h00;

  // Read data is snapshotted at the command byte; MISO moves on falling edges
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_sh_reg <= 8'h00;
      o_spi_miso <= 1'b0;
    end else if (cmd_done) begin
      tx_sh_reg <= rd_data;
    end else if (sclk_fall & ~cs_n & bit_cnt_reg[3]) begin
      o_spi_miso <= tx_sh_reg[7];
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Acknowledge timing and receive turnaround guard
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_SLOT} rfs_ack_st_t;
  localparam logic [12:0] ACK_LOAD = 13'(ACK_DELAY_CYCLES - 1);
  localparam logic [12:0] GUARD_LOAD = 13'(GUARD_CYCLES);
  rfs_ack_st_t ack_st_reg;
  rfs_ack_st_t ack_st_next;
  logic [12:0] ack_cnt_reg;
  logic [12:0] guard_cnt_reg;
  logic ack_fire;
  wire slotted = options_reg[OPT_SLOTTED_BIT];

  // Slotted mode waits for a boundary strictly after the delay has run out
  always_comb begin
    ack_st_next = ack_st_reg;
    ack_fire = 1'b0;
    unique case (ack_st_reg)
      ACK_IDLE: if (i_events.ack_req_end) ack_st_next = ACK_WAIT;
      ACK_WAIT: if (ack_cnt_reg == 13'h0000) begin
        if (slotted) begin
          ack_st_next = ACK_SLOT;
        end else begin
          ack_st_next = ACK_IDLE;
          ack_fire = 1'b1;
        end
      end
      ACK_SLOT: if (i_events.backoff_boundary) begin
        ack_st_next = ACK_IDLE;
        ack_fire = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_st_reg <= ACK_IDLE;
      ack_cnt_reg <= 13'h0000;
      o_ack_start <= 1'b0;
    end else begin
      ack_st_reg <= ack_st_next;
      ack_cnt_reg <= (ack_st_reg == ACK_IDLE) ? ACK_LOAD :
                     (ack_cnt_reg == 13'h0000) ? ack_cnt_reg : ack_cnt_reg - 13'h0001;
      o_ack_start <= ack_fire;
    end
  end

  // Guard only armed when the option is set at the end of reception
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      guard_cnt_reg <= 13'h0000;
      o_rx_guard <= 1'b0;
    end else begin
      if (i_events.rx_end & options_reg[OPT_GUARD_BIT]) begin
        guard_cnt_reg <= GUARD_LOAD;
      end else if (guard_cnt_reg != 13'h0000) begin
        guard_cnt_reg <= guard_cnt_reg - 13'h0001;
      end
      o_rx_guard <= (guard_cnt_reg > 13'h0001);
    end
  end

  // Pin copy of the live assessment
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cca <= 1'b0;
    end else begin
      o_cca <= cca_next;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_sfd_marked;
    i_events.sfd_seen ##1 stat1.sfd;
  endsequence

  a_sfd_set_end: assert property (i_events.sfd_seen |-> s_sfd_marked)
    else $error("start-of-frame bit not set");
  a_sfd_clear_end: assert property (i_events.frame_done && !i_events.sfd_seen
    |=> !stat1.sfd)
    else $error("start-of-frame bit not cleared");
  a_thr_overflow_hold: assert property (i_rxbuf.overflow
    |=> stat1.thr_flag && !stat1.rx_data)
    else $error("overflow flags wrong");
  a_cal_pulse_seen: assert property (i_radio.cal_done |=> stat0_reg.cal_done)
    else $error("calibration pulse not shown");
  a_thr_frame_set: assert property (i_rxbuf.frames_present |=> stat1.thr_flag)
    else $error("threshold flag missed frame");
  a_thr_clear_read: assert property (thr_clear && !thr_set |=> !thr_flag_reg)
    else $error("threshold flag not cleared");
  a_cca_pin_match: assert property (o_cca == stat1.cca)
    else $error("pin and status disagree");
  a_latch_hold_val: assert property (!strobe |=> $stable(latched_reg))
    else $error("latched value moved");
  a_thr_reg_reset: assert property ($rose(i_resetn) |-> rx_thr_reg == RX_THR_RST)
    else $error("threshold reset value");
  a_ack_not_early: assert property (o_ack_start |-> $past(ack_st_reg) != ACK_IDLE)
    else $error("acknowledge too early");
  a_guard_runs_on: assert property ($rose(o_rx_guard) |-> o_rx_guard [*8])
    else $error("guard ended too soon");
endmodule : rfs_status_bank
`default_nettype wire

/* verilog/rfs_unused_placeholder_removed.sv */
// Intentionally empty design unit list
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verif/rfs_spi_host.sv */
// Host microcontroller model speaking the serial register protocol
`timescale 1ns/1ps
`default_nettype none
module rfs_spi_host (
  input wire logic i_sys_clk,
  input wire logic i_miso,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  // Idle: deselected, serial clock parked low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #2;
  endtask : step
  // One 16-bit frame, MSB first; 8-clock half periods cover the pin synchronisers
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] sh;
    sh = {wr, addr, wdata};
    rdata = 8'h00;
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = sh[i];
      step(8);
      if (i < 8) begin
        rdata[i] = i_miso;
      end
      o_sclk = 1'b1;
      step(8);
      o_sclk = 1'b0;
    end
    step(8);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line must not keep its last value
    step(8);
  endtask : xfer
endmodule : rfs_spi_host
`default_nettype wire

/* verif/rfs_status_bank_bench.sv */
// Self-checking bench for the radio frame status bank
`timescale 1ns/1ps
`default_nettype none
module rfs_status_bank_bench;
  import rfs_pkg::*;
  // ----------------------------------------------------------------------
  // Setup: short delays keep the run brief
  // ----------------------------------------------------------------------
  localparam int DLY = 20;
  localparam rfs_events_t E_SFD = 7'h40;
  localparam rfs_events_t E_DONE = 7'h20;
  localparam rfs_events_t E_SAMP = 7'h10;
  localparam rfs_events_t E_TXC = 7'h08;
  localparam rfs_events_t E_ACK = 7'h04;
  localparam rfs_events_t E_RXE = 7'h02;
  localparam rfs_events_t E_BOFF = 7'h01;
  logic i_sys_clk, i_resetn, cs_n, sclk, mosi, miso, cca, ack, guard;
  rfs_radio_t radio;
  rfs_rxbuf_t rxbuf;
  rfs_events_t ev;
  int err_count = 0;
  int checks = 0;
  int ahits, afirst, ghits;
  logic [7:0] rd_v;
  // Clear-channel cases: mode, signal strength, receiving, expected; 0xf7 sits in the band
  logic [11:0] cca_tab [9] = '{12'h003, 12'h7c1, 12'h7dd, 12'h400, 12'h7dc, 12'h801, 12'hbc2,
    12'hfc1, 12'hfc2};

  rfs_status_bank #(.ACK_DELAY_CYCLES(DLY), .GUARD_CYCLES(DLY)) dut_u (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
    .i_spi_mosi(mosi), .i_radio(radio), .i_rxbuf(rxbuf), .i_events(ev),
    .o_spi_miso(miso), .o_cca(cca), .o_ack_start(ack), .o_rx_guard(guard));
  rfs_spi_host host_u (.i_sys_clk(i_sys_clk), .i_miso(miso), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_mosi(mosi));

  // 40 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #2;
  endtask : step
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string name);
    host_u.xfer(1'b0, a, 8'h00, rd_v);
    check(name, rd_v, exp);
  endtask : rdc
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, rd_v);
  endtask : wr
  task automatic pulse(input rfs_events_t e);
    ev = e;
    step(1);
    ev = '0;
  endtask : pulse
  task automatic read_byte();
    rxbuf.byte_read = 1'b1;
    step(1);
    rxbuf.byte_read = 1'b0;
  endtask : read_byte
  // Counts acknowledge pulses and guard cycles; notes the first pulse
  task automatic count(input int n);
    ahits = 0;
    afirst = 0;
    ghits = 0;
    for (int k = 1; k <= n; k++) begin
      step(1);
      if (ack === 1'b1) begin
        ahits++;
        if (afirst == 0) afirst = k;
      end
      if (guard === 1'b1) ghits++;
    end
  endtask : count
  task automatic conclude();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // Watchdog sized well beyond the expected run of some 8300 cycles
  initial begin
    step(60000);
    err_count++;
    conclude();
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    i_resetn = 1'b0;
    radio = '0;
    radio.clear_channel_mode = CCA_BY_RSSI;
    radio.clear_channel_hysteresis = 3'h2;
    radio.rssi = 8'hf0;
    rxbuf = '0;
    ev = '0;
    step(8);
    i_resetn = 1'b1;
    step(6);
    rdc(ADDR_RX_THR, 8'h40, "thr reset");
    rdc(ADDR_OPTIONS, 8'h01, "options reset");
    rdc(ADDR_CLEAR_CHANNEL_THRESHOLD, 8'he0, "clear_channel_threshold reset");
    rdc(ADDR_CAL_STATE, 8'h00, "stat0 reset");
    rdc(ADDR_BUF_CHAN, 8'h00, "stat1 reset");
    rdc(7'h37, 8'h00, "unmapped");
    wr(ADDR_BUF_CHAN, 8'hff);
    rdc(ADDR_BUF_CHAN, 8'h00, "stat1 read only");
    wr(ADDR_RX_THR, 8'hff);
    rdc(ADDR_RX_THR, 8'h7f, "thr reserved");
    wr(ADDR_RX_THR, 8'h05);
    check("cca at reset thr", {7'h0, cca}, 8'h00);
    wr(ADDR_CLEAR_CHANNEL_THRESHOLD, 8'hf8);
    step(3);
    check("cca after thr", {7'h0, cca}, 8'h01);
    rdc(ADDR_CLEAR_CHANNEL_THRESHOLD, 8'hf8, "clear_channel_threshold");
    // Calibration and state field; a done pulse must not linger
    radio.synth_cal_in_progress = 1'b1;
    radio.state = 6'h2a;
    rdc(ADDR_CAL_STATE, 8'h6a, "synth_cal_in_progress");
    radio.cal_done = 1'b1;
    step(1);
    radio.cal_done = 1'b0;
    radio.synth_cal_in_progress = 1'b0;
    rdc(ADDR_CAL_STATE, 8'h2a, "cal end");
    // Receive buffer flags
    radio.clear_channel_mode = CCA_ALWAYS;
    rxbuf.byte_count = 8'd6;
    rxbuf.filtered_count = 8'd6;
    rdc(ADDR_BUF_CHAN, 8'hd0, "thr over");
    check("cca pin", {7'h0, cca}, 8'h01);
    rxbuf.byte_count = 8'd3;
    rxbuf.filtered_count = 8'd3;
    read_byte();
    rdc(ADDR_BUF_CHAN, 8'h90, "thr cleared");
    rxbuf.frames_present = 1'b1;
    rdc(ADDR_BUF_CHAN, 8'hd0, "frame held");
    rxbuf.frames_present = 1'b0;
    rxbuf.overflow = 1'b1;
    rdc(ADDR_BUF_CHAN, 8'h50, "overflow");
    rxbuf = '0;
    read_byte();
    rdc(ADDR_BUF_CHAN, 8'h10, "empty");
    // Start-of-frame, lock and activity
    radio.lock = 1'b1;
    radio.tx_active = 1'b1;
    pulse(E_SFD);
    rdc(ADDR_BUF_CHAN, 8'h36, "tx sfd");
    pulse(E_DONE);
    radio.tx_active = 1'b0;
    radio.rx_active = 1'b1;
    rdc(ADDR_BUF_CHAN, 8'h15, "rx idle");
    pulse(E_SFD);
    rdc(ADDR_BUF_CHAN, 8'h35, "rx sfd");
    pulse(E_DONE);
    radio.lock = 1'b0;
    radio.rx_active = 1'b0;
    rdc(ADDR_BUF_CHAN, 8'h10, "rx done");
    // Every clear-channel mode
    foreach (cca_tab[j]) begin
      {radio.clear_channel_mode, radio.rssi, radio.receiving} = cca_tab[j][11:1];
      step(3);
      check("clear_channel_mode", {7'h0, cca}, {7'h0, cca_tab[j][0]});
    end
    // Sampled value follows both strobes and holds between them
    radio.receiving = 1'b0;
    step(3);
    pulse(E_SAMP);
    radio.receiving = 1'b1;
    rdc(ADDR_BUF_CHAN, 8'h08, "sampled");
    pulse(E_TXC);
    rdc(ADDR_BUF_CHAN, 8'h00, "sampled on tx");
    // Acknowledge timing, guard off
    wr(ADDR_OPTIONS, 8'h00);
    rdc(ADDR_OPTIONS, 8'h00, "options");
    pulse(E_ACK | E_RXE);
    count(40);
    check("ack count", ahits[7:0], 8'h01);
    check("ack delay", afirst[7:0], 8'(DLY));
    check("no guard", ghits[7:0], 8'h00);
    // Slotted acknowledge: an early boundary must be skipped
    wr(ADDR_OPTIONS, 8'h03);
    rdc(ADDR_OPTIONS, 8'h03, "options slotted");
    pulse(E_ACK);
    step(4);
    pulse(E_BOFF);
    count(30);
    check("ack early", ahits[7:0], 8'h00);
    pulse(E_BOFF);
    check("ack on slot", {7'h0, ack}, 8'h01);
    count(3);
    check("ack once", ahits[7:0], 8'h00);
    // Turnaround guard length
    pulse(E_RXE);
    count(40);
    check("guard length", ghits[7:0], 8'(DLY - 1));
    conclude();
  end
endmodule : rfs_status_bank_bench
`default_nettype wire
